// ==== hdl/sfc_pkg.sv ====
// opcodes, frame lengths, info-row layout and timing of the command core
package sfc_pkg;
  localparam logic [7:0] OP_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_UNIQUE = 8'h4B;
  localparam logic [7:0] OP_PARAM = 8'h5A;
  localparam logic [7:0] OP_INFO_PROG = 8'h62;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_MAKER_DEV = 8'h90;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_STD_ID = 8'h9F;
  localparam logic [7:0] OP_LEGACY_ID = 8'hAB;

  // header lengths in whole bytes, opcode included
  localparam logic [2:0] HDR_OPCODE = 3'h1;
  localparam logic [2:0] HDR_ADDR = 3'h4;
  localparam logic [2:0] HDR_DUMMY = 3'h5;
  localparam logic [2:0] LEN_SAT = 3'h7;

  // last byte index of each looping answer
  localparam logic [7:0] LAST_STD_ID = 8'h02;
  localparam logic [7:0] LAST_MAKER_DEV = 8'h01;
  localparam logic [7:0] LAST_UNIQUE = 8'h0F;
  localparam logic [7:0] LAST_PARAM = 8'hFF;

  // bit counter of the link side: the tail loops over one byte
  localparam logic [5:0] CNT_OPCODE_END = 6'h07;
  localparam logic [5:0] CNT_LOOP = 6'h28;
  localparam logic [5:0] CNT_END = 6'h2F;

  // info row layout: addr[23:16] fixed, addr[15:8] = row * step
  localparam int ROW_COUNT = 4;
  localparam int ROW_BYTES = 256;
  localparam logic [7:0] ROW_HIGH = 8'h00;
  localparam logic [7:0] ROW_STEP = 8'h10;
  localparam int LOCK_LSB = 4;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] UNDEF_BYTE = 8'hFF;

  // timing
  localparam int CLK_MHZ = 100;
  localparam int PROG_TIME_US = 1000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
endpackage

// ==== hdl/sfc_sync.sv ====
// two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module sfc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } sfc_sync_t;

  sfc_sync_t q;
  sfc_sync_t next_q;

  // no reset: the chain settles two edges after its clock starts
  always_comb begin
    next_q.meta = i_async;
    next_q.held = q.meta;
  end

  always_ff @(posedge i_clock) begin
    q <= next_q;
  end

  assign o_sync = q.held;
endmodule

// ==== hdl/sfc_cmd_core.sv ====
// serial flash command core: id reads, table read, reset, info row program
// Operation
// - legacy id: opcode, three dummy bytes
// - legacy id code repeats msb first
// - standard id: maker then type word
// - standard id loops until select rises
// - maker/device read takes 24-bit address
// - address bit 0 picks first byte
// - maker and device bytes alternate
// - unique number after address and dummy
// - unique number repeats every sixteen bytes
// - table read framed like fast read
// - undefined table locations return filler
// - reset needs arm frame then reset
// - any other command disarms reset
// - reset aborts running program
// - reset leaves upper status and function bits
// - four rows at 00h..30h of addr[15:8]
// - function bits 7:4 lock rows
// - program needs write enable latch
// - program starts only when select rises
// - while busy only status read answers
// - data wraps within page, last kept
// - each row programs only once
// - legacy id ignored while busy
`timescale 1ns/1ps
module sfc_cmd_core
  import sfc_pkg::*;
#(
  parameter int P_PROG_CYCLES = PROG_CYCLES,
  // identity values below are arbitrary
  parameter logic [7:0] P_MAKER_CODE = 8'h5C,
  parameter logic [7:0] P_DEVICE_CODE = 8'h21,
  parameter logic [15:0] P_TYPE_CAP = 16'h7A31,
  parameter logic [15:0][7:0] P_UNIQUE =
    128'hF0E1D2C3B4A5968778695A4B3C2D1E0F,
  parameter int P_PARAM_BYTES = 16,
  parameter logic [P_PARAM_BYTES-1:0][7:0] P_PARAM_TABLE =
    {96'h0, 32'h50444653}
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  input wire logic [7:0] i_func_reg,
  input wire logic [5:0] i_status_upper,
  input wire logic [9:0] i_info_addr,
  output logic [7:0] o_info_data,
  output logic [ROW_COUNT-1:0] o_row_used,
  output logic o_wel,
  output logic o_wip,
  output logic o_soft_reset
);
  localparam int CNT_W = $clog2(P_PROG_CYCLES + 1);
  localparam int PT_W = $clog2(P_PARAM_BYTES);

  // link side, cleared while select is high
  typedef struct packed {
    logic [5:0] cnt;
    logic [6:0] sh;
    logic out;
    logic [7:0] obyte;
    logic [2:0] obit;
  } sfc_frame_t;

  // frame summary, kept past select rising until the core consumes it
  typedef struct packed {
    logic [7:0] op;
    logic [23:0] addr;
    logic [2:0] len;
    logic aligned;
    logic [7:0] didx;
    logic [ROW_BYTES-1:0] mask;
    logic [ROW_BYTES-1:0][7:0] buff;
  } sfc_sum_t;

  typedef struct packed {
    logic cs_q;
    logic clr;
    logic write_enable_latch;
    logic arm;
    logic busy;
    logic [CNT_W-1:0] left;
    logic rst_pulse;
    logic [ROW_COUNT-1:0] used;
    logic [7:0] rd;
    logic [ROW_COUNT*ROW_BYTES-1:0][7:0] mem;
  } sfc_sys_t;

  localparam sfc_sys_t SYS_RESET = '{
    cs_q: 1'b1,
    clr: 1'b1,
    write_enable_latch: 1'b0,
    arm: 1'b0,
    busy: 1'b0,
    left: '0,
    rst_pulse: 1'b0,
    used: '0,
    rd: '0,
    mem: {(ROW_COUNT*ROW_BYTES){ERASED_BYTE}}
  };

  sfc_frame_t f;
  sfc_frame_t next_f;
  sfc_sum_t s;
  sfc_sum_t next_s;
  sfc_sys_t y;
  sfc_sys_t next_y;

  logic [7:0] stat_l;
  logic busy_l;
  logic cs_s;
  logic [7:0] byte_in;
  logic byte_end;
  logic [7:0] op_now;
  logic [2:0] len_now;
  logic [7:0] tx_byte;
  logic frame_end;
  logic one_op;
  logic [1:0] row;
  logic start;

  function automatic logic [2:0] hdr_len(input logic [7:0] op);
    logic [2:0] n;
    n = 3'h0;
    case (op)
      OP_STATUS, OP_STD_ID: n = HDR_OPCODE;
      OP_LEGACY_ID, OP_MAKER_DEV: n = HDR_ADDR;
      OP_UNIQUE, OP_PARAM: n = HDR_DUMMY;
      default: n = 3'h0;
    endcase
    return n;
  endfunction

  function automatic logic [7:0] last_idx(input logic [7:0] op);
    logic [7:0] n;
    n = 8'h00;
    case (op)
      OP_STD_ID: n = LAST_STD_ID;
      OP_MAKER_DEV: n = LAST_MAKER_DEV;
      OP_UNIQUE: n = LAST_UNIQUE;
      OP_PARAM: n = LAST_PARAM;
      default: n = 8'h00;
    endcase
    return n;
  endfunction

  function automatic logic [7:0] first_idx(input logic [7:0] op,
                                           input logic [23:0] a);
    logic [7:0] n;
    n = 8'h00;
    case (op)
      OP_MAKER_DEV: n = {7'h00, a[0]};
      OP_UNIQUE: n = {4'h0, a[3:0]};
      OP_PARAM: n = a[7:0];
      default: n = 8'h00;
    endcase
    return n;
  endfunction

  function automatic logic [7:0] answer(input logic [7:0] op,
                                        input logic [7:0] idx,
                                        input logic [7:0] st);
    logic [7:0] b;
    b = UNDEF_BYTE;
    case (op)
      OP_STATUS: b = st;
      OP_LEGACY_ID: b = P_DEVICE_CODE;
      OP_STD_ID: begin
        if (idx == 8'h00) begin
          b = P_MAKER_CODE;
        end else if (idx == 8'h01) begin
          b = P_TYPE_CAP[15:8];
        end else begin
          b = P_TYPE_CAP[7:0];
        end
      end
      OP_MAKER_DEV: b = idx[0] ? P_DEVICE_CODE : P_MAKER_CODE;
      OP_UNIQUE: b = P_UNIQUE[idx[3:0]];
      OP_PARAM: begin
        if (32'(idx) < P_PARAM_BYTES) begin
          b = P_PARAM_TABLE[idx[PT_W-1:0]];
        end
      end
      default: b = UNDEF_BYTE;
    endcase
    return b;
  endfunction

  function automatic logic row_ok(input logic [23:0] a);
    return a[23:16] == ROW_HIGH && a[15:8] == ROW_STEP * {6'h00, a[13:12]};
  endfunction

  // core state seen from the link: status byte with latch and busy
  sfc_sync #(
    .WIDTH(8)
  ) u_stat_sync (
    .i_clock(i_sck),
    .i_async({i_status_upper, y.write_enable_latch, y.busy}),
    .o_sync(stat_l)
  );

  sfc_sync #(
    .WIDTH(1)
  ) u_cs_sync (
    .i_clock(i_clock),
    .i_async(i_cs_n),
    .o_sync(cs_s)
  );

  assign busy_l = stat_l[0];

  // link side: sample on rising edges
  always_comb begin
    next_f = f;
    next_s = s;
    byte_in = {f.sh, i_si};
    byte_end = f.cnt[2:0] == 3'h7;
    op_now = (f.cnt == CNT_OPCODE_END) ? byte_in : s.op;
    len_now = s.len + 3'h1;
    next_f.sh = byte_in[6:0];
    next_f.cnt = (f.cnt == CNT_END) ? CNT_LOOP : f.cnt + 6'h01;
    next_s.aligned = byte_end;
    if (f.cnt == CNT_OPCODE_END) begin
      next_s.op = byte_in;
    end
    if (byte_end && s.len != LEN_SAT) begin
      next_s.len = len_now;
    end
    if (byte_end && s.len >= HDR_OPCODE && s.len < HDR_ADDR) begin
      next_s.addr = {s.addr[15:0], byte_in};
    end
    // page offset wraps in eight bits, later bytes overwrite earlier
    if (byte_end && s.op == OP_INFO_PROG && s.len >= HDR_ADDR) begin
      next_s.buff[8'(s.addr[7:0] + s.didx)] = byte_in;
      next_s.mask[8'(s.addr[7:0] + s.didx)] = 1'b1;
      next_s.didx = s.didx + 8'h01;
    end
    if (f.out) begin
      next_f.obit = f.obit + 3'h1;
      if (f.obit == 3'h7) begin
        if (f.obyte == last_idx(s.op)) begin
          next_f.obyte = 8'h00;
        end else begin
          next_f.obyte = f.obyte + 8'h01;
        end
      end
    end else if (byte_end && hdr_len(op_now) != 3'h0 &&
                 len_now == hdr_len(op_now) &&
                 (!busy_l || op_now == OP_STATUS)) begin
      next_f.out = 1'b1;
      next_f.obit = 3'h0;
      next_f.obyte = first_idx(op_now, next_s.addr);
    end
  end

  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  // cleared by the core once it has taken the frame's summary
  always_ff @(posedge i_sck or posedge y.clr) begin
    if (y.clr) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tx_byte = answer(s.op, f.obyte, stat_l);

  // answer bits change on falling edges, msb first
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
    end else begin
      o_so <= f.out & tx_byte[3'h7 - f.obit];
      o_so_oe <= f.out;
    end
  end

  // core side: the summary is quasi-static while select is high
  assign frame_end = cs_s && !y.cs_q;
  assign one_op = s.len == HDR_OPCODE && s.aligned;
  assign row = s.addr[13:12];
  assign start = frame_end && !y.busy && y.write_enable_latch &&
                 s.op == OP_INFO_PROG && s.aligned &&
                 s.len > HDR_ADDR && row_ok(s.addr) &&
                 !i_func_reg[LOCK_LSB + 32'(row)] &&
                 !y.used[row];

  always_comb begin
    next_y = y;
    next_y.cs_q = cs_s;
    next_y.clr = 1'b0;
    next_y.rst_pulse = 1'b0;
    next_y.rd = y.mem[i_info_addr];
    if (y.busy) begin
      next_y.left = y.left - CNT_W'(1);
      if (y.left == CNT_W'(1)) begin
        next_y.busy = 1'b0;
      end
    end
    if (frame_end) begin
      next_y.clr = 1'b1;
      // every finished frame re-decides the arm state
      next_y.arm = one_op && s.op == OP_RESET_ARM;
      if (one_op && s.op == OP_WRITE_EN && !y.busy) begin
        next_y.write_enable_latch = 1'b1;
      end
      if (start) begin
        next_y.write_enable_latch = 1'b0;
        next_y.busy = 1'b1;
        next_y.left = CNT_W'(P_PROG_CYCLES);
        next_y.used[row] = 1'b1;
        // bytes are written up front, so an abort leaves them all written
        for (int i = 0; i < ROW_BYTES; i++) begin
          if (s.mask[i]) begin
            next_y.mem[{row, 8'(i)}] = s.buff[i];
          end
        end
      end
      // upper status and function bits live outside and are not touched
      if (one_op && s.op == OP_RESET && y.arm) begin
        next_y.rst_pulse = 1'b1;
        next_y.busy = 1'b0;
        next_y.left = '0;
        next_y.write_enable_latch = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      y <= SYS_RESET;
    end else begin
      y <= next_y;
    end
  end

  assign o_info_data = y.rd;
  assign o_row_used = y.used;
  assign o_wel = y.write_enable_latch;
  assign o_wip = y.busy;
  assign o_soft_reset = y.rst_pulse;

  a_wel_before_prog: assert property (@(posedge i_clock)
    disable iff (!i_rst_b) $rose(y.busy) |-> $past(y.write_enable_latch) && !y.write_enable_latch)
    else $error("program began without write enable latch");

  // a software reset may cut the program short, so it ends the check
  a_prog_busy_hold: assert property (@(posedge i_clock)
    disable iff (!i_rst_b || o_soft_reset) $rose(y.busy) |-> y.busy[*8])
    else $error("program busy dropped too early");

  a_row_once_only: assert property (@(posedge i_clock)
    disable iff (!i_rst_b) $rose(y.busy) |->
      ($past(y.used) & ~y.used) == '0 &&
      $countones(y.used ^ $past(y.used)) == 1)
    else $error("program start did not claim one fresh row");

  a_lock_kept: assert property (@(posedge i_clock)
    disable iff (!i_rst_b) $rose(y.busy) |->
      ((y.used ^ $past(y.used)) & $past(i_func_reg[7:4])) == '0)
    else $error("locked row was programmed");

  a_row_range: assert property (@(posedge i_clock)
    disable iff (!i_rst_b) $rose(y.busy) |->
      $past(s.addr[23:16]) == ROW_HIGH && $past(s.addr[15:14]) == 2'h0 &&
      $past(s.addr[11:8]) == 4'h0)
    else $error("program started outside the info rows");

  a_arm_drop: assert property (@(posedge i_clock)
    disable iff (!i_rst_b) frame_end &&
      !(one_op && s.op == OP_RESET_ARM) |=> !y.arm)
    else $error("reset arm survived another command");

  a_reset_pair: assert property (@(posedge i_clock)
    disable iff (!i_rst_b) o_soft_reset |->
      $past(y.arm) && $past(frame_end) && !y.arm)
    else $error("software reset without arm frame");

  a_reset_abort: assert property (@(posedge i_clock)
    disable iff (!i_rst_b) o_soft_reset |-> !o_wip && !o_wel ##1 !o_wip)
    else $error("software reset left a program running");

  a_busy_silent: assert property (@(posedge i_sck)
    disable iff (i_cs_n) $rose(f.out) |->
      !$past(busy_l) || s.op == OP_STATUS)
    else $error("answer started while busy");

  a_std_id_loop: assert property (@(posedge i_sck)
    disable iff (i_cs_n) f.out && s.op == OP_STD_ID |->
      f.obyte <= LAST_STD_ID)
    else $error("standard id index left its loop");
endmodule

// ==== bench/sfc_host_model.sv ====
// host side of the serial link: frames commands and captures answers
`timescale 1ns/1ps
module sfc_host_model (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic oe_seen;
  // a low-to-high step at 1 ns gives the link logic a clean clear edge
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b0;
    o_si = 1'b0;
    #1 o_cs_n = 1'b1;
  end
  // sck runs only inside frames; si keeps toggling where it carries nothing
  task automatic frame(input int nrx);
    logic [7:0] b;
    int n;
    n = tx_q.size();
    rx_q.delete();
    oe_seen = 1'b0;
    #7 o_cs_n = 1'b0;
    for (int k = 0; k < n + nrx; k++) begin
      b = (k < n) ? tx_q[k] : 8'h00;
      for (int j = 7; j >= 0; j--) begin
        o_si = (k < n) ? b[j] : ~o_si;
        #32 o_sck = 1'b1;
        if (k >= n) begin
          b[j] = i_so;
          oe_seen = oe_seen | i_so_oe;
        end
        #32 o_sck = 1'b0;
      end
      if (k >= n) rx_q.push_back(b);
    end
    #20 o_cs_n = 1'b1;
    o_si = ~o_si;
    tx_q.delete();
    #100;
  endtask
endmodule

// ==== bench/test_serial_flash_id_reset_otp_cmds.sv ====
// self-checking bench of the serial flash command core
`timescale 1ns/1ps
module test_serial_flash_id_reset_otp_cmds;
  import sfc_pkg::*;
  // identity values are arbitrary
  localparam logic [7:0] MK = 8'h3C;
  localparam logic [7:0] DV = 8'h47;
  localparam logic [15:0] TC = 16'h81E2;
  localparam logic [127:0] UQ = 128'h0123456789ABCDEF1122334455667788;
  localparam logic [127:0] PT = 128'hA1B2C3D4E5F60718293A4B5C6D7E8F90;
  localparam int PC = 2000;
  logic i_clock, i_rst_b, sck, cs_n, si, so, so_oe, write_enable_latch, write_in_progress_flag, srst;
  logic [7:0] func, idata;
  logic [5:0] stat;
  logic [9:0] iaddr;
  logic [3:0] used, used_m;
  logic wel_m;
  logic [7:0] exp_q[$];
  int fails, num_checks, seed, pulses;
  int mem[1024];
  sfc_host_model u_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so),
    .i_so_oe(so_oe));
  sfc_cmd_core #(.P_PROG_CYCLES(PC), .P_MAKER_CODE(MK), .P_DEVICE_CODE(DV),
    .P_TYPE_CAP(TC), .P_UNIQUE(UQ), .P_PARAM_BYTES(16), .P_PARAM_TABLE(PT)
  ) i_dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_sck(sck), .i_cs_n(cs_n),
    .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_func_reg(func),
    .i_status_upper(stat), .i_info_addr(iaddr), .o_info_data(idata),
    .o_row_used(used), .o_wel(write_enable_latch), .o_wip(write_in_progress_flag), .o_soft_reset(srst));
  initial i_clock = 1'b0;
  always #5 i_clock = ~i_clock;
  always @(posedge i_clock) if (srst === 1'b1) pulses++;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_flag(string nm, logic e, logic s);
    chk_byte(nm, {7'h00, e}, {7'h00, s});
  endtask
  task automatic hdr(logic [7:0] op, logic [23:0] a, int n);
    u_host.tx_q.push_back(op);
    // a fourth header byte is the dummy and carries no meaning
    for (int i = 0; i < n; i++)
      u_host.tx_q.push_back((i < 3) ? a[23-8*i -: 8] : 8'($random(seed)));
  endtask
  task automatic rd(int nrx, string nm);
    u_host.frame(nrx);
    for (int i = 0; i < exp_q.size(); i++)
      chk_byte(nm, exp_q[i], u_host.rx_q[i]);
    $display("%s done", nm);
  endtask
  task automatic rd_mem(int a);
    @(negedge i_clock) iaddr = a[9:0];
    repeat (2) @(negedge i_clock);
    chk_byte("info data", mem[a][7:0], idata);
  endtask
  task automatic cmd(logic [7:0] op);
    hdr(op, 24'h0, 0);
    u_host.frame(0);
  endtask
  task automatic prog(logic [23:0] a, int n);
    logic ok;
    logic [7:0] d;
    int r;
    r = a[13:12];
    ok = wel_m && a[23:16] == 8'h00 && (a[15:8] & 8'hCF) == 8'h00
      && !func[4 + r] && !used_m[r] && n > 0;
    hdr(OP_INFO_PROG, a, 3);
    for (int k = 0; k < n; k++) begin
      d = $random(seed);
      u_host.tx_q.push_back(d);
      if (ok) mem[r * 256 + ((a[7:0] + k) % 256)] = d;
    end
    u_host.frame(0);
    if (ok) begin
      used_m[r] = 1'b1;
      wel_m = 1'b0;
    end
    chk_flag("busy", ok, write_in_progress_flag);
    chk_byte("rows used", {4'h0, used_m}, {4'h0, used});
  endtask
  task automatic wait_idle();
    for (int i = 0; i < PC + 100 && write_in_progress_flag !== 1'b0; i++) @(negedge i_clock);
    chk_flag("busy end", 1'b0, write_in_progress_flag);
  endtask
  initial begin
    logic [23:0] a;
    seed = 75785;
    i_rst_b = 1'b0;
    func = 8'h80;
    stat = 6'h2D;
    iaddr = 10'h000;
    used_m = 4'h0;
    wel_m = 1'b0;
    for (int i = 0; i < 1024; i++) mem[i] = 8'hFF;
    repeat (12) @(negedge i_clock);
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_clock);
    hdr(OP_LEGACY_ID, 24'($random(seed)), 3);
    exp_q = '{DV, DV};
    rd(2, "legacy id");
    chk_flag("answer enable", 1'b1, u_host.oe_seen);
    hdr(OP_STD_ID, 24'h0, 0);
    exp_q = '{MK, TC[15:8], TC[7:0], MK};
    rd(4, "standard id");
    for (int b = 0; b < 2; b++) begin
      a = $random(seed);
      a[0] = b[0];
      hdr(OP_MAKER_DEV, a, 3);
      if (b) exp_q = '{DV, MK, DV};
      else exp_q = '{MK, DV, MK};
      rd(3, "maker device");
    end
    a = $random(seed);
    hdr(OP_UNIQUE, a, 4);
    exp_q.delete();
    for (int i = 0; i < 17; i++)
      exp_q.push_back(UQ[((a[3:0] + i) % 16) * 8 +: 8]);
    rd(17, "unique number");
    hdr(OP_PARAM, 24'h00000E, 4);
    exp_q = '{PT[119:112], PT[127:120], UNDEF_BYTE, UNDEF_BYTE};
    rd(4, "param table");
    exp_q.delete();
    prog(24'h001005, 1);
    cmd(OP_WRITE_EN);
    wel_m = 1'b1;
    chk_flag("wel", 1'b1, write_enable_latch);
    prog(24'h0010FE, 3);
    hdr(OP_LEGACY_ID, 24'h0, 3);
    u_host.frame(1);
    chk_flag("answer while busy", 1'b0, u_host.oe_seen);
    hdr(OP_STATUS, 24'h0, 0);
    exp_q = '{{stat, 2'b01}};
    rd(1, "status busy");
    wait_idle();
    rd_mem(10'h1FE);
    rd_mem(10'h1FF);
    rd_mem(10'h100);
    rd_mem(10'h101);
    cmd(OP_WRITE_EN);
    wel_m = 1'b1;
    prog(24'h001020, 2);
    prog(24'h003000, 1);
    prog(24'h000800, 1);
    prog(24'h010000, 1);
    a = $random(seed);
    prog({16'h0000, a[7:0]}, 300);
    cmd(OP_RESET_ARM);
    cmd(OP_RESET);
    wel_m = 1'b0;
    chk_byte("reset pulses", 8'h01, pulses[7:0]);
    chk_flag("busy after reset", 1'b0, write_in_progress_flag);
    chk_flag("wel after reset", 1'b0, write_enable_latch);
    chk_byte("rows kept", {4'h0, used_m}, {4'h0, used});
    hdr(OP_STATUS, 24'h0, 0);
    exp_q = '{{stat, 2'b00}};
    rd(1, "status after reset");
    for (int i = 0; i < 256; i++) rd_mem(i);
    cmd(OP_RESET_ARM);
    hdr(OP_STATUS, 24'h0, 0);
    rd(1, "status between");
    cmd(OP_RESET);
    chk_byte("disarmed pulses", 8'h01, pulses[7:0]);
    report_and_stop();
  end
  initial begin
    #500000;
    fails++;
    report_and_stop();
  end
endmodule
